// ==== hdl/aocp_top.sv ====
// Analog output routing registers and core clock prescaler register bank
`timescale 1ns/10ps
module aocp_top (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Register access from the serial host interface
  input wire aocp_pkg::aocp_req_t req_i,
  input wire logic lock_i,
  output aocp_pkg::aocp_rsp_t rsp_o,
  // Analog output pins
  output aocp_pkg::aocp_route_t analog_pin_one_o,
  output aocp_pkg::aocp_route_t analog_pin_two_o,
  output aocp_pkg::aocp_route_t analog_pin_three_o,
  // Core clock
  output logic core_clock_tick_o,
  output aocp_pkg::aocp_mode_t mode_o,
  // Microcore start gating
  input wire logic core_start_i,
  output logic core_run_o,
  // Code memory access gating
  input wire logic code_memory_req_i,
  output logic code_memory_grant_o,
  input wire logic code_memory_flash_rd_i,
  output logic code_memory_flash_rd_grant_o,
  // Flag pin output enables
  input wire logic [15:0] flag_out_en_i,
  output logic [15:0] flag_out_en_o
);
  import aocp_pkg::*;

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    aocp_aout_cfg_t aout1;
    aocp_aout_cfg_t aout2;
    aocp_aout_cfg_t aout3;
    logic [5:0] div;
    aocp_rsp_t rsp;
    logic run;
    logic mem_grant;
    logic flash_grant;
    logic [15:0] flag_oe;
  } aocp_top_st_t;

  aocp_top_st_t cur_q, nxt_d;
  aocp_mode_t mode;
  logic [15:0] rd_word;

  // --------------------------------------------------------------------------
  // Read-back
  // --------------------------------------------------------------------------

  // Narrow fields sit low and upper bits read zero; unmapped reads give zero
  always_comb begin
    rd_word = 16'h0000;
    unique case (req_i.addr)
      OFS_AOUT1: rd_word = {{(DATA_W - AOUT_W){1'b0}}, cur_q.aout1};
      OFS_AOUT2: rd_word = {{(DATA_W - AOUT_W){1'b0}}, cur_q.aout2};
      OFS_AOUT3: rd_word = {{(DATA_W - AOUT_W){1'b0}}, cur_q.aout3};
      OFS_DIV: rd_word = {{(DATA_W - DIV_W){1'b0}}, cur_q.div};
      default: rd_word = 16'h0000;
    endcase
  end

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------

  // Writes, answers and mode gating; the host is trusted not to change the
  // divider under running cores, the lock is the only hardware guard
  always_comb begin
    nxt_d = cur_q;
    nxt_d.rsp.ack = req_i.wr || req_i.rd;
    nxt_d.rsp.rdata = req_i.rd ? rd_word : 16'h0000;
    if (req_i.wr) begin
      unique case (req_i.addr)
        OFS_AOUT1: nxt_d.aout1 = req_i.wdata[6:0];
        OFS_AOUT2: nxt_d.aout2 = req_i.wdata[6:0];
        OFS_AOUT3: nxt_d.aout3 = req_i.wdata[6:0];
        OFS_DIV: begin
          if (!lock_i) begin
            nxt_d.div = req_i.wdata[5:0];
          end
        end
        default: nxt_d.div = cur_q.div;
      endcase
    end
    nxt_d.run = core_start_i && mode.core_ok;
    nxt_d.mem_grant = code_memory_req_i && mode.code_mem_ok;
    nxt_d.flash_grant = code_memory_flash_rd_i && mode.code_rd_ok;
    nxt_d.flag_oe = mode.flag_drive_ok ? flag_out_en_i : 16'h0000;
  end

  // State register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_q.aout1 <= AOUT_RST;
      cur_q.aout2 <= AOUT_RST;
      cur_q.aout3 <= AOUT_RST;
      cur_q.div <= DIV_RST;
      cur_q.rsp <= '0;
      cur_q.run <= 1'b0;
      cur_q.mem_grant <= 1'b0;
      cur_q.flash_grant <= 1'b0;
      cur_q.flag_oe <= 16'h0000;
    end else begin
      cur_q <= nxt_d;
    end
  end

  // --------------------------------------------------------------------------
  // Channels and divider
  // --------------------------------------------------------------------------

  // Output one
  aocp_aout_chan #(
    .SRC_A(AOCP_SRC_CM1),
    .SRC_B(AOCP_SRC_CM3),
    .SRC_TOP(AOCP_SRC_NONE)
  ) u_aout1 (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .cfg_i(cur_q.aout1),
    .route_o(analog_pin_one_o)
  );

  // Output two
  aocp_aout_chan #(
    .SRC_A(AOCP_SRC_CM2),
    .SRC_B(AOCP_SRC_CM4),
    .SRC_TOP(AOCP_SRC_NONE)
  ) u_aout2 (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .cfg_i(cur_q.aout2),
    .route_o(analog_pin_two_o)
  );

  // Output three, the only one that can show the supply level
  aocp_aout_chan #(
    .SRC_A(AOCP_SRC_CM5),
    .SRC_B(AOCP_SRC_CM6),
    .SRC_TOP(AOCP_SRC_SUPPLY)
  ) u_aout3 (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .cfg_i(cur_q.aout3),
    .route_o(analog_pin_three_o)
  );

  // Core clock divider
  aocp_core_div u_div (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .div_i(cur_q.div),
    .tick_o(core_clock_tick_o),
    .mode_o(mode)
  );

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign rsp_o = cur_q.rsp;
  assign mode_o = mode;
  assign core_run_o = cur_q.run;
  assign code_memory_grant_o = cur_q.mem_grant;
  assign code_memory_flash_rd_grant_o = cur_q.flash_grant;
  assign flag_out_en_o = cur_q.flag_oe;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_div_wr_locked;
    req_i.wr && req_i.addr == OFS_DIV && lock_i;
  endsequence
  sequence s_div_wr_open;
    req_i.wr && req_i.addr == OFS_DIV && !lock_i;
  endsequence
  sequence s_div_rd;
    req_i.rd && req_i.addr == OFS_DIV;
  endsequence
  sequence s_aout1_off;
    req_i.wr && req_i.addr == OFS_AOUT1 && !req_i.wdata[0];
  endsequence

  AST_DIV_LOCKED: assert property (s_div_wr_locked |=> $stable(cur_q.div))
    else $error("locked divider changed");
  AST_DIV_WRITE: assert property (s_div_wr_open |=> cur_q.div == $past(req_i.wdata[5:0]))
    else $error("divider write lost");
  AST_AOUT_UNLOCKED: assert property (req_i.wr && req_i.addr == OFS_AOUT2 && lock_i
      |=> cur_q.aout2 == $past(req_i.wdata[6:0]))
    else $error("output register blocked by lock");
  AST_DIV_READ: assert property (s_div_rd ##1 rsp_o.ack
      |-> rsp_o.rdata == {10'h000, $past(cur_q.div)})
    else $error("divider read-back wrong or upper bits set");
  AST_ACK_ALWAYS: assert property (req_i.wr || req_i.rd |=> rsp_o.ack)
    else $error("register access not answered");
  AST_RUN_GATED: assert property (core_run_o |-> $past(cur_q.div, 2) != 6'h00)
    else $error("cores run with divider zero");
  AST_FLAG_GATED: assert property (cur_q.div == 6'h00 [*2] |=> flag_out_en_o == 16'h0000)
    else $error("flag pins driven with divider zero");
  AST_FLASH_RD: assert property (code_memory_flash_rd_grant_o
      |-> $past(cur_q.div, 2) >= DIV_MIN_CODE_RD)
    else $error("code read granted below setting two");
  AST_PIN_OFF: assert property (s_aout1_off |=> ##1 !analog_pin_one_o.oe)
    else $error("pin one still driven after disable");
  AST_SUPPLY_ROUTE: assert property (cur_q.aout3.en && cur_q.aout3.sel == SEL_SUPPLY
      |=> analog_pin_three_o.src == AOCP_SRC_SUPPLY)
    else $error("supply level not routed to pin three");

  // --------------------------------------------------------------------------
  // Register bank checks
  // --------------------------------------------------------------------------

  // Steps of a register access, shared by the bank properties below
  sequence s_aout1_wr;
    req_i.wr && req_i.addr == OFS_AOUT1;
  endsequence
  sequence s_aout3_wr;
    req_i.wr && req_i.addr == OFS_AOUT3;
  endsequence
  sequence s_no_wr;
    !req_i.wr;
  endsequence
  sequence s_idle;
    !req_i.wr && !req_i.rd;
  endsequence
  sequence s_wr_only;
    req_i.wr && !req_i.rd;
  endsequence
  sequence s_rd_unmapped;
    req_i.rd && req_i.addr != OFS_AOUT1 && req_i.addr != OFS_AOUT2
      && req_i.addr != OFS_AOUT3 && req_i.addr != OFS_DIV;
  endsequence
  sequence s_aout2_off;
    req_i.wr && req_i.addr == OFS_AOUT2 && !req_i.wdata[0];
  endsequence
  sequence s_aout3_off;
    req_i.wr && req_i.addr == OFS_AOUT3 && !req_i.wdata[0];
  endsequence

  // Output registers take every write, whatever the lock says
  AST_AOUT1_WRITE: assert property (s_aout1_wr |=> cur_q.aout1 == $past(req_i.wdata[6:0]))
    else $error("output one write lost");
  AST_AOUT3_WRITE: assert property (s_aout3_wr |=> cur_q.aout3 == $past(req_i.wdata[6:0]))
    else $error("output three write lost");

  // Without a write the bank holds; a stray update would move a pin
  AST_AOUT_HOLD: assert property (s_no_wr |=> $stable(cur_q.aout1))
    else $error("output one changed without a write");
  AST_DIV_HOLD: assert property (s_no_wr |=> $stable(cur_q.div))
    else $error("divider changed without a write");

  // Answer is a one-cycle pulse and carries no data for writes
  AST_ACK_PULSE: assert property (s_idle |=> !rsp_o.ack)
    else $error("answer without an access");
  AST_WR_RDATA_ZERO: assert property (s_wr_only |=> rsp_o.rdata == 16'h0000)
    else $error("write answered with data");
  AST_UNMAPPED_ZERO: assert property (s_rd_unmapped |=> rsp_o.rdata == 16'h0000)
    else $error("unmapped read returned data");

  // Disabling outputs two and three floats their pins two cycles on
  AST_PIN_TWO_OFF: assert property (s_aout2_off |=> ##1 !analog_pin_two_o.oe)
    else $error("pin two still driven after disable");
  AST_PIN_THREE_OFF: assert property (s_aout3_off |=> ##1 !analog_pin_three_o.oe)
    else $error("pin three still driven after disable");

  // --------------------------------------------------------------------------
  // Mode gating checks
  // --------------------------------------------------------------------------

  // Grants follow request and permission one cycle later
  AST_RUN_FOLLOWS: assert property (core_start_i && mode_o.core_ok |=> core_run_o)
    else $error("core start not honoured");
  AST_MEM_FOLLOWS: assert property (code_memory_req_i && mode_o.code_mem_ok
      |=> code_memory_grant_o)
    else $error("code memory access not granted");
  AST_MEM_GATED: assert property (code_memory_grant_o
      |-> $past(cur_q.div, 2) >= DIV_MIN_CORE)
    else $error("code memory granted with divider zero");
  AST_FLASH_FOLLOWS: assert property (code_memory_flash_rd_i && mode_o.code_rd_ok
      |=> code_memory_flash_rd_grant_o)
    else $error("code read not granted");
  AST_FLAG_FOLLOWS: assert property (mode_o.flag_drive_ok
      |=> flag_out_en_o == $past(flag_out_en_i))
    else $error("flag drive request lost");

  // Divider zero: no cores, and a core tick on every system clock
  AST_MODE_ZERO_DIV: assert property (cur_q.div == 6'h00 |=> !mode_o.core_ok)
    else $error("cores allowed with divider zero");
  AST_TICK_DIV_ZERO: assert property (cur_q.div == 6'h00 [*2] |=> core_clock_tick_o)
    else $error("tick missing with divider zero");
endmodule

// ==== hdl/aocp_pkg.sv ====
// Constants and types for the analog output routing and core clock prescaler bank
// ----------------------------------------------------------------------------
// Overview of operation
// - Enable with a non-reserved select code drives pin, otherwise pin high impedance
// - Gain code selects 1.33, 2.0, 3.0, 5.33
// - Unity override forces gain 1.0
// - Output one routes blocks 1, 3, reference
// - Output two routes blocks 2, 4, reference
// - Output three routes 5, 6, reference, supply
// - Six bit divider, upper bits read zero
// - Core clock equals system clock over value+1
// - Register access allowed at every divider value
// - Divider sets core, code memory permissions
// ----------------------------------------------------------------------------
package aocp_pkg;

  // --------------------------------------------------------------------------
  // Widths and register offsets
  // --------------------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned AOUT_W = 7;
  localparam int unsigned DIV_W = 6;
  localparam int unsigned FLAG_W = 16;
  localparam logic [9:0] OFS_AOUT1 = 10'h197;
  localparam logic [9:0] OFS_AOUT2 = 10'h198;
  localparam logic [9:0] OFS_AOUT3 = 10'h199;
  localparam logic [9:0] OFS_DIV = 10'h1a0;

  // --------------------------------------------------------------------------
  // Reset values, field codes and mode thresholds
  // --------------------------------------------------------------------------
  localparam logic [6:0] AOUT_RST = 7'h00;
  localparam logic [5:0] DIV_RST = 6'h00;
  localparam logic [2:0] SEL_BLK_A = 3'h0;
  localparam logic [2:0] SEL_BLK_B = 3'h1;
  localparam logic [2:0] SEL_REF = 3'h5;
  localparam logic [2:0] SEL_SUPPLY = 3'h7;
  localparam logic [1:0] GCODE_133 = 2'h0;
  localparam logic [1:0] GCODE_200 = 2'h1;
  localparam logic [1:0] GCODE_300 = 2'h2;
  localparam logic [1:0] GCODE_533 = 2'h3;
  localparam logic [5:0] DIV_MIN_CORE = 6'h01;
  localparam logic [5:0] DIV_MIN_CODE_RD = 6'h02;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    AOCP_SRC_NONE, AOCP_SRC_CM1, AOCP_SRC_CM2, AOCP_SRC_CM3, AOCP_SRC_CM4,
    AOCP_SRC_CM5, AOCP_SRC_CM6, AOCP_SRC_REF2V5, AOCP_SRC_SUPPLY
  } aocp_src_t;
  typedef enum logic [2:0] {
    AOCP_GAIN_1P00, AOCP_GAIN_1P33, AOCP_GAIN_2P00, AOCP_GAIN_3P00, AOCP_GAIN_5P33
  } aocp_gain_t;
  // Bit order matches the register: override 6, select 5:3, gain 2:1, enable 0
  typedef struct packed {
    logic unity;
    logic [2:0] sel;
    logic [1:0] gain;
    logic en;
  } aocp_aout_cfg_t;
  typedef struct packed {
    logic oe;
    aocp_src_t src;
    aocp_gain_t gain;
  } aocp_route_t;
  typedef struct packed {
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [15:0] wdata;
  } aocp_req_t;
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
  } aocp_rsp_t;
  typedef struct packed {
    logic core_ok;
    logic code_mem_ok;
    logic code_rd_ok;
    logic flag_drive_ok;
  } aocp_mode_t;

endpackage

// ==== hdl/aocp_aout_chan.sv ====
// One analog output channel: source decode, gain decode and pin enable
`timescale 1ns/10ps
module aocp_aout_chan #(
  parameter aocp_pkg::aocp_src_t SRC_A = aocp_pkg::AOCP_SRC_CM1,
  parameter aocp_pkg::aocp_src_t SRC_B = aocp_pkg::AOCP_SRC_CM3,
  parameter aocp_pkg::aocp_src_t SRC_TOP = aocp_pkg::AOCP_SRC_NONE
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Configuration from the register bank
  input wire aocp_pkg::aocp_aout_cfg_t cfg_i,
  // Analog routing controls for the pin
  output aocp_pkg::aocp_route_t route_o
);
  import aocp_pkg::*;

  typedef struct packed {
    aocp_route_t route;
  } aocp_chan_st_t;

  aocp_chan_st_t cur_q, nxt_d;

  // Decode source and gain; a reserved code leaves the pin floating
  always_comb begin
    nxt_d = cur_q;
    unique case (cfg_i.sel)
      SEL_BLK_A: nxt_d.route.src = SRC_A;
      SEL_BLK_B: nxt_d.route.src = SRC_B;
      SEL_REF: nxt_d.route.src = AOCP_SRC_REF2V5;
      SEL_SUPPLY: nxt_d.route.src = SRC_TOP;
      default: nxt_d.route.src = AOCP_SRC_NONE;
    endcase
    if (cfg_i.unity) begin
      nxt_d.route.gain = AOCP_GAIN_1P00;
    end else begin
      unique case (cfg_i.gain)
        GCODE_133: nxt_d.route.gain = AOCP_GAIN_1P33;
        GCODE_200: nxt_d.route.gain = AOCP_GAIN_2P00;
        GCODE_300: nxt_d.route.gain = AOCP_GAIN_3P00;
        GCODE_533: nxt_d.route.gain = AOCP_GAIN_5P33;
      endcase
    end
    nxt_d.route.oe = cfg_i.en && (nxt_d.route.src != AOCP_SRC_NONE);
  end

  // State register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_q <= '{route: '{oe: 1'b0, src: AOCP_SRC_NONE, gain: AOCP_GAIN_1P00}};
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign route_o = cur_q.route;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  AST_PIN_FLOATS: assert property (!cfg_i.en |=> !route_o.oe)
    else $error("pin driven while disabled");
  AST_UNITY_GAIN: assert property (cfg_i.unity |=> route_o.gain == AOCP_GAIN_1P00)
    else $error("override did not force unity gain");
  AST_GAIN_533: assert property (!cfg_i.unity && cfg_i.gain == GCODE_533
      |=> route_o.gain == AOCP_GAIN_5P33)
    else $error("gain code 11 not decoded");
  AST_REF_ROUTE: assert property (cfg_i.en && cfg_i.sel == SEL_REF
      |=> route_o.oe && route_o.src == AOCP_SRC_REF2V5)
    else $error("reference not routed");
endmodule

// ==== hdl/aocp_core_div.sv ====
// Core clock divider: one tick every value+1 system clocks, plus mode permissions
`timescale 1ns/10ps
module aocp_core_div (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Divider setting
  input wire logic [5:0] div_i,
  // Core clock enable pulse and permitted modes
  output logic tick_o,
  output aocp_pkg::aocp_mode_t mode_o
);
  import aocp_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic tick;
    aocp_mode_t mode;
  } aocp_div_st_t;

  aocp_div_st_t cur_q, nxt_d;

  // Count up to the setting; >= keeps a lowered setting from overrunning
  always_comb begin
    nxt_d = cur_q;
    if (cur_q.cnt >= div_i) begin
      nxt_d.cnt = 6'h00;
      nxt_d.tick = 1'b1;
    end else begin
      nxt_d.cnt = cur_q.cnt + 6'h01;
      nxt_d.tick = 1'b0;
    end
    nxt_d.mode.core_ok = div_i >= DIV_MIN_CORE;
    nxt_d.mode.code_mem_ok = div_i >= DIV_MIN_CORE;
    nxt_d.mode.code_rd_ok = div_i >= DIV_MIN_CODE_RD;
    nxt_d.mode.flag_drive_ok = div_i >= DIV_MIN_CORE;
  end

  // State register
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_q <= '0;
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign tick_o = cur_q.tick;
  assign mode_o = cur_q.mode;

  // Helper: distance between ticks while the setting stays put
  logic [6:0] gap_q;
  logic [5:0] seen_q;
  logic chg_q;
  logic valid_q;
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gap_q <= 7'h00;
      seen_q <= 6'h00;
      chg_q <= 1'b1;
      valid_q <= 1'b0;
    end else begin
      seen_q <= div_i;
      gap_q <= tick_o ? 7'h01 : gap_q + 7'h01;
      chg_q <= tick_o ? (div_i != seen_q) : (chg_q || div_i != seen_q);
      valid_q <= valid_q || tick_o;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  AST_TICK_PERIOD: assert property (tick_o && valid_q && !chg_q && div_i == seen_q
      |-> gap_q == {1'b0, div_i} + 7'h01)
    else $error("core clock period is not setting plus one");
  AST_CODE_RD_MODE: assert property (div_i < DIV_MIN_CODE_RD |=> !mode_o.code_rd_ok)
    else $error("code read allowed below setting two");
endmodule

// ==== sim/aocp_host_model.sv ====
// Host model: register master standing in for the microcontroller
`timescale 1ns/10ps
module aocp_host_model (
  // Clock
  input wire logic mclk_i,
  // Register port toward the device
  output aocp_pkg::aocp_req_t req_o,
  output logic lock_o,
  input wire aocp_pkg::aocp_rsp_t rsp_i
);
  import aocp_pkg::*;

  // Idle bus and unlocked divider at time zero
  initial begin
    req_o = '0;
    lock_o = 1'b0;
  end

  // ----------------------------------------------------------------------
  // One word access
  // ----------------------------------------------------------------------
  // A quiet cycle follows every access, keeping the rate low at divider one
  task automatic access(input logic [9:0] addr, input logic wr, input logic [15:0] wdata,
                        output logic ack, output logic [15:0] rdata);
    @(posedge mclk_i);
    req_o <= '{addr: addr, wr: wr, rd: ~wr, wdata: wdata};
    @(posedge mclk_i);
    // Released lines show the inverse, never the stale value
    req_o <= '{addr: ~addr, wr: 1'b0, rd: 1'b0, wdata: ~wdata};
    #1;
    ack = rsp_i.ack;
    rdata = rsp_i.rdata;
  endtask

  // Lock the divider while cores run
  task automatic set_lock(input logic v);
    @(posedge mclk_i);
    lock_o <= v;
  endtask
endmodule

// ==== sim/aout_select_clock_prescaler_test.sv ====
// Self-checking bench for the analog output and core clock divider bank
`timescale 1ns/10ps
module aout_select_clock_prescaler_test;
  import aocp_pkg::*;

  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  aocp_req_t req;
  logic lock;
  aocp_rsp_t rsp;
  aocp_route_t pin [3];
  aocp_mode_t mode;
  logic tick, core_start, core_run, cm_req, cm_gnt, fr_req, fr_gnt;
  logic [15:0] flag_in, flag_out, w, rd;
  logic [5:0] d, d_last;
  logic ack;
  aocp_route_t e, g;
  int n_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int gap;
  logic [31:0] rng = 32'h3;
  logic [5:0] divs [5] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h3f};

  aocp_top dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req), .lock_i(lock), .rsp_o(rsp),
    .analog_pin_one_o(pin[0]), .analog_pin_two_o(pin[1]), .analog_pin_three_o(pin[2]),
    .core_clock_tick_o(tick), .mode_o(mode), .core_start_i(core_start), .core_run_o(core_run),
    .code_memory_req_i(cm_req), .code_memory_grant_o(cm_gnt),
    .code_memory_flash_rd_i(fr_req), .code_memory_flash_rd_grant_o(fr_gnt),
    .flag_out_en_i(flag_in), .flag_out_en_o(flag_out)
  );

  aocp_host_model host (.mclk_i(mclk_i), .req_o(req), .lock_o(lock), .rsp_i(rsp));

  // 10 MHz system clock
  always #50 mclk_i = ~mclk_i;

  // Hang guard; a full run takes well under a thousand cycles
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Expected pin routing; reserved codes leave the pin floating
  function automatic aocp_route_t exp_route(input int ch, input logic [6:0] c);
    aocp_route_t r;
    r.src = AOCP_SRC_NONE;
    case (c[5:3])
      3'h0: r.src = ch == 0 ? AOCP_SRC_CM1 : ch == 1 ? AOCP_SRC_CM2 : AOCP_SRC_CM5;
      3'h1: r.src = ch == 0 ? AOCP_SRC_CM3 : ch == 1 ? AOCP_SRC_CM4 : AOCP_SRC_CM6;
      3'h5: r.src = AOCP_SRC_REF2V5;
      3'h7: r.src = ch == 2 ? AOCP_SRC_SUPPLY : AOCP_SRC_NONE;
      default: r.src = AOCP_SRC_NONE;
    endcase
    r.oe = c[0] && (r.src != AOCP_SRC_NONE);
    case (c[2:1])
      2'h0: r.gain = AOCP_GAIN_1P33;
      2'h1: r.gain = AOCP_GAIN_2P00;
      2'h2: r.gain = AOCP_GAIN_3P00;
      default: r.gain = AOCP_GAIN_5P33;
    endcase
    if (c[6]) r.gain = AOCP_GAIN_1P00;
    return r;
  endfunction

  task automatic chk_reg(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pin(input string what, input aocp_route_t exp, input aocp_route_t got);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Distance in cycles between two consecutive core ticks
  task automatic tick_gap(output int n);
    n = 0;
    @(posedge mclk_i);
    #1;
    while (tick !== 1'b1 && n < 200) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (tick !== 1'b1 && n < 200);
  endtask

  task automatic test_done();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    core_start = 1'b0;
    cm_req = 1'b0;
    fr_req = 1'b0;
    flag_in = '0;
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    // Reset values
    for (int i = 0; i < 4; i++) begin
      host.access(i < 3 ? OFS_AOUT1 + 10'(i) : OFS_DIV, 1'b0, '0, ack, rd);
      chk_reg("reset value", 16'h0000, rd);
      if (i < 3) chk_reg("reset oe", 16'h0000, {15'h0, pin[i].oe});
    end
    chk_reg("reset mode", 16'h0000, {12'h0, mode});
    // Every select code on every channel, then every gain code, then random
    for (int ch = 0; ch < 3; ch++) begin
      for (int k = 0; k < 24; k++) begin
        rng = xs(rng);
        w = rng[15:0];
        if (k < 8) begin
          w[5:3] = k[2:0];
          w[0] = 1'b1;
        end else if (k < 12) begin
          w[6:0] = {4'h0, k[1:0], 1'b1};
        end
        host.access(OFS_AOUT1 + 10'(ch), 1'b1, w, ack, rd);
        chk_reg("write ack", 16'h0001, {15'h0, ack});
        host.access(OFS_AOUT1 + 10'(ch), 1'b0, '0, ack, rd);
        chk_reg("aout readback", {9'h0, w[6:0]}, rd);
        e = exp_route(ch, w[6:0]);
        g = pin[ch];
        // Gain of a floating pin is of no consequence
        if (e.src == AOCP_SRC_NONE) begin
          e.gain = AOCP_GAIN_1P00;
          g.gain = AOCP_GAIN_1P00;
        end
        chk_pin("route", e, g);
      end
    end
    // Divider boundaries plus one random value
    for (int i = 0; i < 6; i++) begin
      rng = xs(rng);
      d = i < 5 ? divs[i] : rng[5:0];
      @(posedge mclk_i);
      core_start <= 1'b0;
      host.access(OFS_DIV, 1'b1, {rng[15:6], d}, ack, rd);
      host.access(OFS_DIV, 1'b0, '0, ack, rd);
      chk_reg("divider readback", {10'h0, d}, rd);
      chk_reg("read ack", 16'h0001, {15'h0, ack});
      @(posedge mclk_i);
      core_start <= 1'b1;
      cm_req <= 1'b1;
      fr_req <= 1'b1;
      flag_in <= rng[31:16];
      repeat (3) @(posedge mclk_i);
      #1;
      chk_reg("mode", {12'h0, d >= 6'h1, d >= 6'h1, d >= 6'h2, d >= 6'h1}, {12'h0, mode});
      chk_reg("grants", {13'h0, d >= 6'h1, d >= 6'h1, d >= 6'h2}, {13'h0, core_run, cm_gnt, fr_gnt});
      chk_reg("flag drive", d >= 6'h1 ? rng[31:16] : 16'h0, flag_out);
      tick_gap(gap);
      chk_reg("tick gap", 16'(d) + 16'h1, 16'(gap));
      d_last = d;
    end
    // Locked divider ignores writes, output registers stay writable
    @(posedge mclk_i);
    core_start <= 1'b0;
    host.set_lock(1'b1);
    host.access(OFS_DIV, 1'b1, {10'h0, ~d_last}, ack, rd);
    host.access(OFS_DIV, 1'b0, '0, ack, rd);
    chk_reg("locked divider", {10'h0, d_last}, rd);
    host.access(OFS_AOUT2, 1'b1, 16'h005b, ack, rd);
    host.access(OFS_AOUT2, 1'b0, '0, ack, rd);
    chk_reg("aout under lock", 16'h005b, rd);
    host.set_lock(1'b0);
    host.access(OFS_DIV, 1'b1, 16'h0004, ack, rd);
    host.access(OFS_DIV, 1'b0, '0, ack, rd);
    chk_reg("unlocked divider", 16'h0004, rd);
    // Unmapped neighbours read zero and are still answered
    host.access(10'h196, 1'b0, '0, ack, rd);
    chk_reg("unmapped read", 16'h0000, rd);
    host.access(10'h1a1, 1'b0, '0, ack, rd);
    chk_reg("unmapped ack", 16'h0001, {15'h0, ack});
    test_done();
  end
endmodule
